/* File: rtl/eca_loader.sv */
// Serial memory configuration autoloader with APB status port
//
// Function
// - Bytes zero to five of the image form the station MAC address.
// - Control bits 1:0 equal 01 replace built-in vendor and product IDs.
// - Control bits 5:4 equal 01 apply wake bit 10 and EEE word.
// - Control bits 7:6 equal 01 apply wake bits 11 and 3:0.
// - Control bits 11:10 equal 01 apply wake bit 7, LED mode.
// - Control bits 9:8 equal 01 apply wake bits 6:4.
// - Control bits 13:12 equal 01 apply wake bits 9:8.
// - Control bits 15:14 equal 01 apply wake bits 15:12 and word 11.
// - Word 4 is the vendor ID, built-in default otherwise.
// - Word 5 is the product ID, built-in default otherwise.
// - EEE word low seven bits go to register 3FH bits 6:0.
// - Polarity bit set makes wake-on-LAN output active low.
// - Wake event enable bit goes to register 0 bit 6.
// - Bit 4 enables magic-packet wake during suspend, default off.
// - Bit 5 enables link-change wake during suspend, default off.
// - Set bit keeps internal PHY enabled after power-on, default off.
// - Management interrupt enable goes to register 0FH bit 7.
// - Fiber bit puts PHY in fiber mode, default copper.
// - Bit 7 selects LED mode 1, default mode 0.
// - Bit 14 enables automatic crossover, enabled by default.
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps

module eca_loader #(
    parameter logic [15:0] DEF_VID = 16'h1d50, // Arbitrary value
    parameter logic [15:0] DEF_PID = 16'h6001  // Arbitrary value
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Serial memory pins
    output logic                    ee_cs,
    output logic                    ee_sk,
    output logic                    ee_di,
    input  wire logic               ee_do,
    // Wake event from the MAC side
    input  wire logic               wol_event,
    output logic                    wake_on_lan_output,
    // Applied configuration
    output eca_pkg::eca_cfg_type    cfg,
    output logic                    load_done
);

    eca_pkg::eca_state_type state_reg;
    logic [15:0] words_mem [eca_pkg::N_WORDS];
    logic [5:0]  tick_cnt_reg;
    logic        tick;
    logic [3:0]  word_idx_reg;
    logic [4:0]  bit_cnt_reg;
    logic [15:0] shift_reg;
    logic [8:0]  out_reg;
    logic [8:0]  cmd_bits;
    logic        do_meta_reg;
    logic        do_sync_reg;
    logic        boot_reg;
    logic        reload_reg;
    logic        start_req;
    logic        busy;
    logic [15:0] alc;
    logic [15:0] wake_mask;
    logic [15:0] wake_next;
    logic [31:0] rd_data;
    logic        rd_hit;
    logic        apb_take;
    logic        apb_done;

    // Enable field test; only the exact pattern 01 counts
    function automatic logic field_on(input logic [15:0] w, input int pos);
        return w[pos+:2] == eca_pkg::FIELD_ON;
    endfunction

    localparam eca_pkg::eca_cfg_type CFG_RESET = '{
        mac_addr: 48'h0,
        usb_vid:  DEF_VID,
        usb_pid:  DEF_PID,
        eee_ctrl: eca_pkg::EEE_DEFAULT,
        ext_word: eca_pkg::EXT_DEFAULT,
        alc_word: 16'h0000,
        opt:      11'h400
    };

    assign busy      = (state_reg != eca_pkg::S_IDLE);
    assign start_req = boot_reg | reload_reg;
    assign cmd_bits  = {eca_pkg::CMD_READ, 2'h0, word_idx_reg};
    assign tick      = (tick_cnt_reg == eca_pkg::SK_HALF_LAST);
    assign apb_take  = psel & penable & ~pready;
    assign apb_done  = psel & penable & pready;

    // Data line from the memory is asynchronous to ref_clk
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            do_meta_reg <= 1'b0;
            do_sync_reg <= 1'b0;
        end else begin
            do_meta_reg <= ee_do;
            do_sync_reg <= do_meta_reg;
        end
    end

    // Half-period divider for the serial clock, idle outside a load
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_reg <= 6'h00;
        end else if (!busy || tick) begin
            tick_cnt_reg <= 6'h00;
        end else begin
            tick_cnt_reg <= 6'(tick_cnt_reg + 6'h01);
        end
    end

    // Power-on load request, consumed when the loader starts
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            boot_reg <= 1'b1;
        end else if (!busy) begin
            boot_reg <= 1'b0;
        end
    end

    // Word-read sequencer; one read frame per word, all twelve words
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg    <= eca_pkg::S_IDLE;
            word_idx_reg <= 4'h0;
            bit_cnt_reg  <= 5'h00;
            shift_reg    <= 16'h0000;
            out_reg      <= 9'h000;
            ee_cs        <= 1'b0;
            ee_sk        <= 1'b0;
            ee_di        <= 1'b0;
        end else begin
            case (state_reg)
                eca_pkg::S_IDLE: begin
                    if (start_req) begin
                        word_idx_reg <= 4'h0;
                        ee_cs        <= 1'b1;
                        ee_di        <= 1'b1; // Start bit
                        state_reg    <= eca_pkg::S_START;
                    end
                end
                eca_pkg::S_START: begin
                    bit_cnt_reg <= 5'h00;
                    out_reg     <= {cmd_bits[7:0], 1'b0};
                    if (tick) begin
                        state_reg <= eca_pkg::S_SHIFT;
                    end
                end
                eca_pkg::S_SHIFT: begin
                    if (tick && !ee_sk) begin
                        ee_sk <= 1'b1;
                    end else if (tick) begin
                        // Sample late in the high phase, data long settled
                        ee_sk <= 1'b0;
                        if (bit_cnt_reg >= eca_pkg::DATA_FIRST) begin
                            shift_reg <= {shift_reg[14:0], do_sync_reg};
                        end
                        if (bit_cnt_reg == eca_pkg::FRAME_LAST) begin
                            ee_cs     <= 1'b0;
                            ee_di     <= 1'b0;
                            state_reg <= eca_pkg::S_GAP;
                        end else begin
                            bit_cnt_reg <= 5'(bit_cnt_reg + 5'h01);
                            ee_di       <= out_reg[8];
                            out_reg     <= {out_reg[7:0], 1'b0};
                        end
                    end
                end
                eca_pkg::S_GAP: begin
                    // Chip select stays low a full half period between words
                    if (tick && word_idx_reg == eca_pkg::LAST_WORD) begin
                        state_reg <= eca_pkg::S_APPLY;
                    end else if (tick) begin
                        word_idx_reg <= 4'(word_idx_reg + 4'h1);
                        ee_cs        <= 1'b1;
                        ee_di        <= 1'b1;
                        state_reg    <= eca_pkg::S_START;
                    end
                end
                eca_pkg::S_APPLY: begin
                    state_reg <= eca_pkg::S_IDLE;
                end
                default: begin
                    state_reg <= eca_pkg::S_IDLE;
                    ee_cs     <= 1'b0;
                    ee_sk     <= 1'b0;
                end
            endcase
        end
    end

    // Image store, written once per word at the end of the gap after its frame
    always_ff @(posedge ref_clk) begin
        if (state_reg == eca_pkg::S_GAP && tick) begin
            words_mem[word_idx_reg] <= shift_reg;
        end
    end

    // Merge enabled wake bits over their defaults
    always_comb begin
        alc       = words_mem[eca_pkg::W_ALC];
        wake_mask = 16'h0000;
        if (field_on(alc, eca_pkg::F_EEE)) begin
            wake_mask = wake_mask | eca_pkg::MASK_EEE;
        end
        if (field_on(alc, eca_pkg::F_PWR)) begin
            wake_mask = wake_mask | eca_pkg::MASK_PWR;
        end
        if (field_on(alc, eca_pkg::F_WAKE)) begin
            wake_mask = wake_mask | eca_pkg::MASK_WAKE;
        end
        if (field_on(alc, eca_pkg::F_LED)) begin
            wake_mask = wake_mask | eca_pkg::MASK_LED;
        end
        if (field_on(alc, eca_pkg::F_PHY)) begin
            wake_mask = wake_mask | eca_pkg::MASK_PHY;
        end
        if (field_on(alc, eca_pkg::F_XTRA)) begin
            wake_mask = wake_mask | eca_pkg::MASK_XTRA;
        end
        // Unmasked bits keep defaults whatever the field holds
        wake_next = (eca_pkg::WAKE_DEFAULT & ~wake_mask)
                  | (words_mem[eca_pkg::W_WAKE] & wake_mask);
    end

    // Settings change only once the whole image is in, all at one edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg <= CFG_RESET;
        end else if (state_reg == eca_pkg::S_APPLY) begin
            cfg.mac_addr <= {words_mem[eca_pkg::W_MAC0][7:0],
                             words_mem[eca_pkg::W_MAC0][15:8],
                             words_mem[eca_pkg::W_MAC1][7:0],
                             words_mem[eca_pkg::W_MAC1][15:8],
                             words_mem[eca_pkg::W_MAC2][7:0],
                             words_mem[eca_pkg::W_MAC2][15:8]};
            cfg.usb_vid <= field_on(alc, eca_pkg::F_IDS) ?
                           words_mem[eca_pkg::W_VID] : DEF_VID;
            cfg.usb_pid <= field_on(alc, eca_pkg::F_IDS) ?
                           words_mem[eca_pkg::W_PID] : DEF_PID;
            cfg.eee_ctrl <= field_on(alc, eca_pkg::F_EEE) ?
                            words_mem[eca_pkg::W_EEE][6:0] :
                            eca_pkg::EEE_DEFAULT;
            cfg.ext_word <= field_on(alc, eca_pkg::F_XTRA) ?
                            words_mem[eca_pkg::W_EXT] :
                            eca_pkg::EXT_DEFAULT;
            cfg.alc_word <= alc;
            cfg.opt.wol_active_low <= wake_next[eca_pkg::B_WOL_LOW];
            cfg.opt.wol_pulse      <= wake_next[eca_pkg::B_WOL_PULSE];
            cfg.opt.wakeup_event_en <= wake_next[eca_pkg::B_WAKE_EN];
            cfg.opt.magic_wake_en  <= wake_next[eca_pkg::B_MAGIC];
            cfg.opt.link_wake_en   <= wake_next[eca_pkg::B_LINK];
            cfg.opt.led_mode       <= wake_next[eca_pkg::B_LED];
            cfg.opt.eee_option     <= wake_next[eca_pkg::B_EEE_OPT];
            cfg.opt.management_interrupt <= wake_next[eca_pkg::B_MGMT];
            cfg.opt.phy_enable     <= wake_next[eca_pkg::B_PHY_ON];
            cfg.opt.fiber_mode     <= wake_next[eca_pkg::B_FIBER];
            cfg.opt.auto_crossover <= wake_next[eca_pkg::B_XOVER];
        end
    end

    // Done flag drops on every new load so software sees it restart
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            load_done <= 1'b0;
        end else if (state_reg == eca_pkg::S_APPLY) begin
            load_done <= 1'b1;
        end else if (!busy && start_req) begin
            load_done <= 1'b0;
        end
    end

    // Wake output polarity follows the applied setting
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wake_on_lan_output <= 1'b0;
        end else begin
            wake_on_lan_output <= wol_event ^ cfg.opt.wol_active_low;
        end
    end

    // Register read mux
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (paddr)
            eca_pkg::A_CTRL: rd_data = 32'h0000_0000;
            eca_pkg::A_STATUS: begin
                rd_data[eca_pkg::ST_DONE] = load_done;
                rd_data[eca_pkg::ST_BUSY] = busy;
            end
            eca_pkg::A_MAC_LO: rd_data = cfg.mac_addr[31:0];
            eca_pkg::A_MAC_HI: rd_data = {16'h0000, cfg.mac_addr[47:32]};
            eca_pkg::A_IDS:    rd_data = {cfg.usb_pid, cfg.usb_vid};
            eca_pkg::A_WAKE:   rd_data = {21'h000000, cfg.opt};
            eca_pkg::A_EEE:    rd_data = {25'h0000000, cfg.eee_ctrl};
            eca_pkg::A_EXT:    rd_data = {16'h0000, cfg.ext_word};
            eca_pkg::A_ALC:    rd_data = {16'h0000, cfg.alc_word};
            default:           rd_hit  = 1'b0;
        endcase
    end

    // APB answer one cycle into the access phase; a trade for flop outputs
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_take;
            if (apb_take) begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_data;
                pslverr <= ~rd_hit;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // Reload request; a write during a load queues one more pass
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reload_reg <= 1'b0;
        end else if (apb_done && pwrite && paddr == eca_pkg::A_CTRL
                     && pwdata[eca_pkg::CTRL_RELOAD]) begin
            reload_reg <= 1'b1;
        end else if (!busy) begin
            reload_reg <= 1'b0;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    mac_from_image_a: assert property (
        $rose(load_done) |-> cfg.mac_addr[47:40] == words_mem[0][7:0]
            && cfg.mac_addr[7:0] == words_mem[2][15:8])
        else $error("MAC address not taken from image bytes");

    ids_loaded_a: assert property (
        $rose(load_done) && cfg.alc_word[1:0] == 2'h1
            |-> cfg.usb_vid == words_mem[4] && cfg.usb_pid == words_mem[5])
        else $error("USB IDs not replaced from image");

    ids_default_a: assert property (
        $rose(load_done) && cfg.alc_word[1:0] != 2'h1
            |-> cfg.usb_vid == DEF_VID && cfg.usb_pid == DEF_PID)
        else $error("USB IDs left default not kept");

    eee_word_a: assert property (
        $rose(load_done) |-> cfg.eee_ctrl == ((cfg.alc_word[5:4] == 2'h1)
            ? words_mem[6][6:0] : 7'h00))
        else $error("EEE control bits wrong after load");

    xover_default_a: assert property (
        $rose(load_done) && cfg.alc_word[15:14] != 2'h1
            |-> cfg.opt.auto_crossover)
        else $error("Auto crossover not enabled by default");

    wake_enable_a: assert property (
        $rose(load_done) |-> cfg.opt.wakeup_event_en ==
            (cfg.alc_word[7:6] == 2'h1 && words_mem[7][2]))
        else $error("Wake event enable wrong after load");

    led_mode_a: assert property (
        $rose(load_done) |-> cfg.opt.led_mode ==
            (cfg.alc_word[11:10] == 2'h1 && words_mem[7][7]))
        else $error("LED mode wrong after load");

    phy_bits_a: assert property (
        $rose(load_done) |-> {cfg.opt.fiber_mode, cfg.opt.phy_enable} ==
            ((cfg.alc_word[13:12] == 2'h1) ? words_mem[7][9:8] : 2'h0))
        else $error("PHY power or fiber bits wrong after load");

    cfg_only_at_done_a: assert property (
        !$stable(cfg) |-> $rose(load_done) && $past(state_reg) == 3'h6)
        else $error("Configuration changed before load finished");

    wol_polarity_a: assert property (
        ##1 wake_on_lan_output ==
            ($past(wol_event) ^ $past(cfg.opt.wol_active_low)))
        else $error("Wake output polarity wrong");

    sk_half_a: assert property (
        $changed(ee_sk) |=> $stable(ee_sk) [*8])
        else $error("Serial clock half period too short");

    apb_answer_a: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("APB answer not one cycle");

    load_seen_c: cover property ($rose(load_done));
    ids_used_c: cover property ($rose(load_done) && cfg.alc_word[1:0] == 2'h1);
    reload_busy_c: cover property (busy && reload_reg);
    wol_low_c: cover property (cfg.opt.wol_active_low && !wake_on_lan_output);

endmodule

/* File: rtl/eca_pkg.sv */
// Constants, types and register map of the configuration autoloader
package eca_pkg;

    // Word indexes of the serial memory image
    localparam int W_MAC0 = 0;
    localparam int W_MAC1 = 1;
    localparam int W_MAC2 = 2;
    localparam int W_ALC  = 3;
    localparam int W_VID  = 4;
    localparam int W_PID  = 5;
    localparam int W_EEE  = 6;
    localparam int W_WAKE = 7;
    localparam int W_EXT  = 11;
    localparam int N_WORDS = 12;
    localparam logic [3:0] LAST_WORD = 4'hb;

    // Two-bit enable fields of the auto-load control word
    localparam int F_IDS  = 0;
    localparam int F_EEE  = 4;
    localparam int F_PWR  = 6;
    localparam int F_WAKE = 8;
    localparam int F_LED  = 10;
    localparam int F_PHY  = 12;
    localparam int F_XTRA = 14;
    localparam logic [1:0] FIELD_ON = 2'h1;

    // Wake-up mode word bits governed by each enable field
    localparam logic [15:0] MASK_EEE  = 16'h0400;
    localparam logic [15:0] MASK_PWR  = 16'h080f;
    localparam logic [15:0] MASK_WAKE = 16'h0070;
    localparam logic [15:0] MASK_LED  = 16'h0080;
    localparam logic [15:0] MASK_PHY  = 16'h0300;
    localparam logic [15:0] MASK_XTRA = 16'hf000;

    // Wake-up mode word bit positions
    localparam int B_WOL_LOW   = 0;
    localparam int B_WOL_PULSE = 1;
    localparam int B_WAKE_EN   = 2;
    localparam int B_MAGIC     = 4;
    localparam int B_LINK      = 5;
    localparam int B_LED       = 7;
    localparam int B_PHY_ON    = 8;
    localparam int B_FIBER     = 9;
    localparam int B_EEE_OPT   = 10;
    localparam int B_MGMT      = 11;
    localparam int B_XOVER     = 14;

    // Values after reset of the applied settings
    localparam logic [15:0] WAKE_DEFAULT = 16'h4000;
    localparam logic [6:0]  EEE_DEFAULT  = 7'h00;
    localparam logic [15:0] EXT_DEFAULT  = 16'h0000;

    // Serial clock timing, 500 ns least half period
    localparam int SK_HALF_NS = 500;
    localparam int CLK_MHZ    = 125;
    localparam int SK_HALF_CYC = (SK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam logic [5:0] SK_HALF_LAST = 6'(SK_HALF_CYC - 1);

    // Read frame: start bit, opcode, six address bits, dummy, 16 data
    localparam logic [2:0] CMD_READ   = 3'h6;
    localparam logic [4:0] DATA_FIRST = 5'h0a;
    localparam logic [4:0] FRAME_LAST = 5'h19;

    // APB register byte addresses and status bits
    localparam logic [11:0] A_CTRL   = 12'h000;
    localparam logic [11:0] A_STATUS = 12'h004;
    localparam logic [11:0] A_MAC_LO = 12'h008;
    localparam logic [11:0] A_MAC_HI = 12'h00c;
    localparam logic [11:0] A_IDS    = 12'h010;
    localparam logic [11:0] A_WAKE   = 12'h014;
    localparam logic [11:0] A_EEE    = 12'h018;
    localparam logic [11:0] A_EXT    = 12'h01c;
    localparam logic [11:0] A_ALC    = 12'h020;
    localparam int CTRL_RELOAD = 0;
    localparam int ST_DONE     = 0;
    localparam int ST_BUSY     = 1;

    // Decoded option bits, order is the WAKE register layout from bit 10
    typedef struct packed {
        logic auto_crossover;
        logic fiber_mode;
        logic phy_enable;
        logic management_interrupt;
        logic eee_option;
        logic led_mode;
        logic link_wake_en;
        logic magic_wake_en;
        logic wakeup_event_en;
        logic wol_pulse;
        logic wol_active_low;
    } eca_opt_type;

    // Applied configuration
    typedef struct packed {
        logic [47:0] mac_addr;
        logic [15:0] usb_vid;
        logic [15:0] usb_pid;
        logic [6:0]  eee_ctrl;
        logic [15:0] ext_word;
        logic [15:0] alc_word;
        eca_opt_type opt;
    } eca_cfg_type;

    // Loader states, Gray coded along the read path
    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_START = 3'h1,
        S_SHIFT = 3'h3,
        S_GAP   = 3'h2,
        S_APPLY = 3'h6
    } eca_state_type;

endpackage

/* File: tb/eca_eeprom_model.sv */
// Behavioural serial configuration memory answering read frames
`timescale 1ns/1ps

module eca_eeprom_model (
    // Serial memory pins
    input  wire logic         ee_cs,
    input  wire logic         ee_sk,
    input  wire logic         ee_di,
    output logic              ee_do,
    // Stored image, word k at bits 16k+15:16k
    input  wire logic [191:0] image
);
    logic [4:0]  rise_cnt;
    logic [5:0]  addr;
    logic [15:0] word;

    initial begin
        ee_do = 1'b0;
        rise_cnt = 5'h00;
        addr = 6'h00;
    end

    // Words past the image read as zero
    assign word = (addr < 6'h0c) ? image[addr * 16 +: 16] : 16'h0000;

    // Deselect flips the line so a stale bit is never mistaken for data
    always @(posedge ee_sk or negedge ee_cs) begin
        if (!ee_cs) begin
            rise_cnt <= 5'h00;
            ee_do <= ~ee_do;
        end else begin
            if (rise_cnt >= 5'h03 && rise_cnt <= 5'h08) begin
                addr <= {addr[4:0], ee_di};
            end
            if (rise_cnt >= 5'h0a) begin
                ee_do <= word[25 - rise_cnt];
            end else begin
                ee_do <= ~ee_do; // Changing pattern while command shifts in
            end
            rise_cnt <= rise_cnt + 5'h01;
        end
    end
endmodule

/* File: tb/eca_loader_bench.sv */
// Self-checking bench for the configuration autoloader
`timescale 1ns/1ps

module eca_loader_bench;
    localparam logic [15:0]  BV = 16'h1234; // Arbitrary value
    localparam logic [15:0]  BP = 16'h5678; // Arbitrary value
    // Image with every field enabled, wake word has bit 14 clear
    localparam logic [191:0] IMG_A = {16'hc3e1, 48'h0, 16'h0e95, 16'h00a5,
        16'h0c0d, 16'h0a0b, 16'h5555, 16'hbc9a, 16'h7856, 16'h3412};
    // Image whose enable fields hold 00, 10 and 11 only
    localparam logic [191:0] IMG_B = {16'hffff, 48'h0, 16'h4fb7, 16'h007f,
        16'h0c0d, 16'h0a0b, 16'he38e, 16'h0506, 16'h0304, 16'h0102};
    logic                 ref_clk, rst, psel, penable, pwrite, pready;
    logic                 pslverr, ee_cs, ee_sk, ee_di, ee_do, e;
    logic                 wol_event, wol_out, load_done;
    logic [11:0]          paddr;
    logic [31:0]          pwdata, prdata, q;
    logic [191:0]         image;
    eca_pkg::eca_cfg_type cfg, ea;
    int                   err_count, checks_done;

    eca_loader #(.DEF_VID(BV), .DEF_PID(BP)) eca_loader_i (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ee_cs(ee_cs), .ee_sk(ee_sk),
        .ee_di(ee_di), .ee_do(ee_do), .wol_event(wol_event),
        .wake_on_lan_output(wol_out), .cfg(cfg), .load_done(load_done));

    eca_eeprom_model eca_eeprom_model_i (.ee_cs(ee_cs), .ee_sk(ee_sk),
        .ee_di(ee_di), .ee_do(ee_do), .image(image));

    // Expected settings worked out from an image
    function automatic eca_pkg::eca_cfg_type exp_cfg(logic [191:0] im);
        logic [15:0]          a, k;
        logic [7:0]           f;
        logic [10:0]          m, o;
        eca_pkg::eca_cfg_type c;
        a = im[63:48];
        k = im[127:112];
        for (int i = 0; i < 8; i++) f[i] = (a[2*i +: 2] == 2'h1);
        c.mac_addr = {im[7:0], im[15:8], im[23:16], im[31:24],
                      im[39:32], im[47:40]};
        c.usb_vid = f[0] ? im[79:64] : BV;
        c.usb_pid = f[0] ? im[95:80] : BP;
        c.eee_ctrl = f[2] ? im[102:96] : 7'h00;
        c.ext_word = f[7] ? im[191:176] : 16'h0000;
        c.alc_word = a;
        m = {f[7], f[6], f[6], f[3], f[2], f[5], f[4], f[4], f[3:3], f[3:3],
             f[3:3]};
        o = {k[14], k[9], k[8], k[11], k[10], k[7], k[5], k[4], k[2], k[1],
             k[0]};
        c.opt = (o & m) | (11'h400 & ~m);
        return c;
    endfunction

    // One APB transfer, entered just after a rising edge
    task automatic apb(logic [11:0] a, logic w, logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic chk_cfg(eca_pkg::eca_cfg_type x);
        checks_done++;
        if (cfg !== x) begin
            err_count++;
            $display("Error cfg expected %h seen %h", x, cfg);
        end
    endtask

    task automatic chk_val(string n, logic [31:0] x, logic [31:0] s);
        checks_done++;
        if (s !== x) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask

    // Bounded wait for the end of a load
    task automatic wait_done;
        int n;
        n = 0;
        while (load_done !== 1'b1 && n < 60000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 60000) err_count++;
        @(posedge ref_clk);
    endtask

    task automatic complete_run;
        $display("Mismatches %0d in %0d checks", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Two full loads take about 82k cycles
    initial begin
        repeat (95000) @(posedge ref_clk);
        err_count++;
        complete_run;
    end

    // Power-up load, then a reload with every field disabled
    initial begin
        {rst, psel, penable, pwrite, wol_event} = 5'h10;
        {paddr, pwdata} = 44'h0;
        err_count = 0;
        checks_done = 0;
        image = IMG_A;
        ea = exp_cfg(IMG_A);
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (1000) @(posedge ref_clk);
        chk_cfg(exp_cfg(192'h0));
        chk_val("done", 32'h0, {31'h0, load_done});
        wait_done;
        chk_cfg(ea);
        chk_cfg(ea);
        apb(eca_pkg::A_MAC_LO, 1'b0, 32'h0);
        chk_val("mac_lo", ea.mac_addr[31:0], q);
        apb(eca_pkg::A_IDS, 1'b0, 32'h0);
        chk_val("ids", {ea.usb_pid, ea.usb_vid}, q);
        apb(12'h024, 1'b0, 32'h0);
        chk_val("slverr", 32'h1, {31'h0, e});
        wol_event <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk_val("wol_low", 32'h0, {31'h0, wol_out});
        image <= IMG_B;
        apb(eca_pkg::A_CTRL, 1'b1, 32'h1);
        repeat (100) @(posedge ref_clk);
        chk_cfg(ea);
        apb(eca_pkg::A_STATUS, 1'b0, 32'h0);
        chk_val("status", 32'h2, q);
        wait_done;
        chk_cfg(exp_cfg(IMG_B));
        chk_val("wol_high", 32'h1, {31'h0, wol_out});
        complete_run;
    end
endmodule
